// ===== eco_pkg.sv
// Package: register map, field positions and sizes of the overflow control block
package eco_pkg;
  localparam int unsigned NUM_CNT = 31;
  localparam int unsigned CNT_W   = 64;
  localparam int unsigned LOW_W   = 32;
  localparam int unsigned IDX_W   = 5;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_CTRL_LO  = 8'h00;
  localparam logic [7:0] OFF_CTRL_HI  = 8'h04;
  localparam logic [7:0] OFF_HYP_CFG  = 8'h08;
  localparam logic [7:0] OFF_OVF_STAT = 8'h0C;
  localparam logic [7:0] OFF_OVF_CLR  = 8'h10;
  localparam logic [7:0] OFF_CNT_SEL  = 8'h14;
  localparam logic [7:0] OFF_CNT_LO   = 8'h18;
  localparam logic [7:0] OFF_CNT_HI   = 8'h1C;
  localparam logic [7:0] OFF_FROZEN   = 8'h20;
  // Control register fields
  localparam int unsigned BIT_FREEZE = 9;
  localparam int unsigned BIT_LONG   = 7;
  localparam int unsigned N_LSB     = 11;
  localparam int unsigned N_MSB     = 15;
  // Hypervisor config register fields
  localparam int unsigned LIM_LSB   = 0;
  localparam int unsigned LIM_MSB   = 4;
  localparam int unsigned BIT_EL2_IMPL = 8;
  localparam int unsigned BIT_EL2_64   = 9;
  localparam int unsigned BIT_EL2_EN   = 10;
  localparam int unsigned BIT_LOW_EL   = 11;
  // Reset values
  localparam logic [IDX_W-1:0] N_RESET    = 5'h14;
  localparam logic [IDX_W-1:0] LIM_RESET  = 5'h14;
endpackage : eco_pkg

// ===== eco_cnt_mem.sv
// Counter storage: 64-bit event counters with registered read port
`timescale 1ns/1ns
`default_nettype none
module eco_cnt_mem (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic [eco_pkg::NUM_CNT-1:0]          inc,
  input  wire logic                                 wr_en,
  input  wire logic                                 wr_hi,
  input  wire logic [eco_pkg::IDX_W-1:0]            wr_idx,
  input  wire logic [31:0]                          wr_data,
  input  wire logic [eco_pkg::IDX_W-1:0]            rd_idx,
  output logic      [eco_pkg::CNT_W-1:0]            rd_data,
  output logic      [eco_pkg::NUM_CNT-1:0]          wrap32,
  output logic      [eco_pkg::NUM_CNT-1:0]          wrap64
);
  logic [eco_pkg::CNT_W-1:0] cnt_q [eco_pkg::NUM_CNT];
  logic [eco_pkg::CNT_W-1:0] cnt_d [eco_pkg::NUM_CNT];
  logic [eco_pkg::CNT_W-1:0] rd_d;

  genvar g;
  generate
    for (g = 0; g < eco_pkg::NUM_CNT; g++) begin : g_cnt
      always_comb begin
        cnt_d[g]  = cnt_q[g] + eco_pkg::CNT_W'(inc[g]);
        wrap32[g] = inc[g] && (cnt_q[g][eco_pkg::LOW_W-1:0] == '1);
        wrap64[g] = inc[g] && (cnt_q[g] == '1);
        if (wr_en && (wr_idx == eco_pkg::IDX_W'(g))) begin
          if (wr_hi) begin
            cnt_d[g] = {wr_data, cnt_q[g][eco_pkg::LOW_W-1:0]};
          end else begin
            cnt_d[g] = {cnt_q[g][eco_pkg::CNT_W-1:eco_pkg::LOW_W], wr_data};
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[g] <= '0;
        end else begin
          cnt_q[g] <= cnt_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_d = '0;
    if (rd_idx < eco_pkg::IDX_W'(eco_pkg::NUM_CNT)) begin
      rd_d = cnt_q[rd_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_d;
    end
  end
endmodule : eco_cnt_mem
`default_nettype wire

// ===== eco_overflow_ctrl.sv
// Event counter overflow control: freeze-on-overflow and long-counter selection
// Notes on behaviour
// RULE_01: Control bit 9 enables freezing; cleared, counters ignore recorded overflow.
// RULE_02: Frozen range stops while any overflow bit below the affected count is set.
// RULE_03: With nonzero affected count, both controls act on counters below it only.
// RULE_04: Counters above the range and the cycle counter are never frozen.
// RULE_05: Freezing holds even when the hypervisor level is disabled.
// RULE_06: Affected count is hypervisor limit if that level is 64-bit, else counter count.
// RULE_07: Control bit 7 clear: overflow flagged on wrap of low 32 bits.
// RULE_08: Control bit 7 set: overflow flagged only on full 64-bit wrap.
// RULE_09: Long-counter bit picks the width at which overflow status is set.
// RULE_10: Bits 15:11 give counter count; lower levels read hypervisor limit if enabled.
// RULE_11: Frozen counter resumes the cycle after overflow bits clear, no increment lost.
// RULE_12: Control bits 10 and 8 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module eco_overflow_ctrl (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [eco_pkg::NUM_CNT-1:0]      event_in,
  input  wire logic                             cycle_tick,
  output logic      [eco_pkg::CNT_W-1:0]        cycle_count,
  output logic      [eco_pkg::NUM_CNT-1:0]      frozen
);
  typedef enum logic [1:0] {ECO_IDLE = 2'b00, ECO_WAIT = 2'b01, ECO_DONE = 2'b11} eco_state_t;

  localparam int unsigned NC = eco_pkg::NUM_CNT;

  eco_state_t                state_q, state_d;
  logic                      freeze_q, freeze_d, long_q, long_d;
  logic [eco_pkg::IDX_W-1:0] n_q, n_d, hyp_lim_q, hyp_lim_d;
  logic                      el2_impl_q, el2_impl_d, el2_64_q, el2_64_d;
  logic                      el2_en_q, el2_en_d, low_el_q, low_el_d;
  logic [NC-1:0]             ovf_q, ovf_d;
  logic [eco_pkg::IDX_W-1:0] sel_q, sel_d;
  logic [31:0]               prdata_d;
  logic                      err_d, err_q;
  logic [eco_pkg::CNT_W-1:0] cyc_q, cyc_d;
  logic [eco_pkg::IDX_W-1:0] aff_cnt;
  logic [NC-1:0]             in_range, inc, wrap32, wrap64, ovf_set, ovf_clr;
  logic                      any_ovf;
  logic [eco_pkg::CNT_W-1:0] cnt_rd;
  logic                      access, wr, cnt_wr, cnt_wr_hi;

  // Range mask: counters 0 .. lim-1, all counters when lim is zero
  function automatic logic [NC-1:0] range_mask(input logic [eco_pkg::IDX_W-1:0] lim);
    logic [NC-1:0] m;
    m = '0;
    for (int i = 0; i < NC; i++) begin
      m[i] = (lim == '0) || (eco_pkg::IDX_W'(i) < lim);
    end
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign aff_cnt  = (el2_impl_q && el2_64_q) ? hyp_lim_q : n_q; // RULE_06
  assign in_range = range_mask(aff_cnt); // RULE_03
  // Freeze ignores the enable of the hypervisor level on purpose
  assign any_ovf  = |(ovf_q & range_mask(aff_cnt)); // RULE_02 RULE_05
  // Combinational gate so a counter resumes the cycle after the last clear
  assign frozen   = (freeze_q && any_ovf) ? in_range : '0; // RULE_01 RULE_04 RULE_11
  assign inc      = event_in & ~frozen;

  // Long mode only applies in range; counters above always flag at 32 bits
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      ovf_set[i] = (long_q && in_range[i]) ? wrap64[i] : wrap32[i]; // RULE_07 RULE_08 RULE_09
    end
  end

  assign access    = psel && penable && (state_q == ECO_WAIT);
  assign wr        = access && pwrite && (pstrb != 4'h0);
  assign cnt_wr    = wr && (hit(paddr, eco_pkg::OFF_CNT_LO) || hit(paddr, eco_pkg::OFF_CNT_HI));
  assign cnt_wr_hi = hit(paddr, eco_pkg::OFF_CNT_HI);
  assign ovf_clr   = (wr && hit(paddr, eco_pkg::OFF_OVF_CLR)) ? pwdata[NC-1:0] : '0;

  eco_cnt_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (inc),
    .wr_en   (cnt_wr),
    .wr_hi   (cnt_wr_hi),
    .wr_idx  (sel_q),
    .wr_data (pwdata),
    .rd_idx  (sel_q),
    .rd_data (cnt_rd),
    .wrap32  (wrap32),
    .wrap64  (wrap64)
  );

  // Read data registered in the wait cycle, so every access takes one wait state
  always_comb begin
    state_d    = state_q;
    freeze_d   = freeze_q;
    long_d     = long_q;
    n_d        = n_q;
    hyp_lim_d  = hyp_lim_q;
    el2_impl_d = el2_impl_q;
    el2_64_d   = el2_64_q;
    el2_en_d   = el2_en_q;
    low_el_d   = low_el_q;
    sel_d      = sel_q;
    prdata_d   = prdata;
    err_d      = err_q;
    cyc_d      = cyc_q + eco_pkg::CNT_W'(cycle_tick); // RULE_04
    ovf_d      = (ovf_q & ~ovf_clr) | ovf_set; // RULE_11
    unique case (state_q)
      ECO_IDLE: begin
        if (psel && !penable) begin
          state_d = ECO_WAIT;
        end
      end
      ECO_WAIT: begin
        state_d  = ECO_DONE;
        err_d    = 1'b0;
        prdata_d = 32'h0000_0000;
        if (!pwrite) begin
          unique case (paddr)
            eco_pkg::OFF_CTRL_LO: begin
              prdata_d[eco_pkg::BIT_FREEZE] = freeze_q;
              prdata_d[eco_pkg::BIT_LONG]   = long_q;
              prdata_d[eco_pkg::N_MSB:eco_pkg::N_LSB] =
                (low_el_q && el2_impl_q && el2_en_q) ? hyp_lim_q : n_q; // RULE_10 RULE_12
            end
            eco_pkg::OFF_CTRL_HI:  prdata_d = 32'h0000_0000;
            eco_pkg::OFF_HYP_CFG: begin
              prdata_d[eco_pkg::LIM_MSB:eco_pkg::LIM_LSB] = hyp_lim_q;
              prdata_d[eco_pkg::BIT_EL2_IMPL] = el2_impl_q;
              prdata_d[eco_pkg::BIT_EL2_64]   = el2_64_q;
              prdata_d[eco_pkg::BIT_EL2_EN]   = el2_en_q;
              prdata_d[eco_pkg::BIT_LOW_EL]   = low_el_q;
            end
            eco_pkg::OFF_OVF_STAT,
            eco_pkg::OFF_OVF_CLR:  prdata_d[NC-1:0] = ovf_q;
            eco_pkg::OFF_CNT_SEL:  prdata_d[eco_pkg::IDX_W-1:0] = sel_q;
            eco_pkg::OFF_CNT_LO:   prdata_d = cnt_rd[eco_pkg::LOW_W-1:0];
            eco_pkg::OFF_CNT_HI:   prdata_d = cnt_rd[eco_pkg::CNT_W-1:eco_pkg::LOW_W];
            eco_pkg::OFF_FROZEN:   prdata_d[NC-1:0] = frozen;
            default:               err_d = 1'b1;
          endcase
        end else begin
          unique case (paddr)
            eco_pkg::OFF_CTRL_LO: begin
              // Bits 10 and 8 have no storage; an all-zero strobe leaves every field alone
              if (wr) begin
                freeze_d = pwdata[eco_pkg::BIT_FREEZE]; // RULE_01 RULE_12
                long_d   = pwdata[eco_pkg::BIT_LONG]; // RULE_07
              end
            end
            eco_pkg::OFF_HYP_CFG: begin
              if (wr) begin
                hyp_lim_d  = pwdata[eco_pkg::LIM_MSB:eco_pkg::LIM_LSB];
                el2_impl_d = pwdata[eco_pkg::BIT_EL2_IMPL];
                el2_64_d   = pwdata[eco_pkg::BIT_EL2_64];
                el2_en_d   = pwdata[eco_pkg::BIT_EL2_EN];
                low_el_d   = pwdata[eco_pkg::BIT_LOW_EL];
              end
            end
            eco_pkg::OFF_CNT_SEL: begin
              if (wr) begin
                sel_d = pwdata[eco_pkg::IDX_W-1:0];
              end
            end
            eco_pkg::OFF_CTRL_HI,
            eco_pkg::OFF_OVF_CLR,
            eco_pkg::OFF_CNT_LO,
            eco_pkg::OFF_CNT_HI:   err_d = 1'b0;
            default:               err_d = 1'b1;
          endcase
        end
      end
      ECO_DONE: begin
        state_d = (psel && !penable) ? ECO_WAIT : ECO_IDLE;
      end
      default: state_d = ECO_IDLE;
    endcase
  end

  assign pready      = (state_q == ECO_DONE);
  assign pslverr     = pready && err_q;
  assign cycle_count = cyc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ECO_IDLE;
      freeze_q   <= 1'b0;
      long_q     <= 1'b0;
      n_q        <= eco_pkg::N_RESET;
      hyp_lim_q  <= eco_pkg::LIM_RESET;
      el2_impl_q <= 1'b0;
      el2_64_q   <= 1'b0;
      el2_en_q   <= 1'b0;
      low_el_q   <= 1'b0;
      sel_q      <= '0;
      prdata     <= 32'h0000_0000;
      err_q      <= 1'b0;
      cyc_q      <= '0;
      ovf_q      <= '0;
    end else begin
      state_q    <= state_d;
      freeze_q   <= freeze_d;
      long_q     <= long_d;
      n_q        <= n_d;
      hyp_lim_q  <= hyp_lim_d;
      el2_impl_q <= el2_impl_d;
      el2_64_q   <= el2_64_d;
      el2_en_q   <= el2_en_d;
      low_el_q   <= low_el_d;
      sel_q      <= sel_d;
      prdata     <= prdata_d;
      err_q      <= err_d;
      cyc_q      <= cyc_d;
      ovf_q      <= ovf_d;
    end
  end
endmodule : eco_overflow_ctrl
`default_nettype wire

// ===== eco_overflow_ctrl_monitor.sv
// Checker: port-level properties of the overflow control block
`timescale 1ns/1ns
`default_nettype none
module eco_overflow_ctrl_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [30:0] event_in,
  input wire logic        cycle_tick,
  input wire logic [63:0] cycle_count,
  input wire logic [30:0] frozen
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  assign acc = psel && penable && !pready;
  assign wr  = acc && pwrite && (pstrb != 4'h0);
  property p_ready_wait; acc |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer after access");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside answer");
  property p_freeze_off;
    wr && paddr == eco_pkg::OFF_CTRL_LO && !pwdata[eco_pkg::BIT_FREEZE] |=> (frozen == '0) [*2];
  endproperty
  a_freeze_off: assert property (p_freeze_off) else $error("frozen with freeze off");
  // Range always starts at counter 0, so a freeze mask is a run of low ones
  property p_frz_mask; (frozen & (frozen + 31'h1)) == '0; endproperty
  a_frz_mask: assert property (p_frz_mask) else $error("freeze mask not a low range");
  property p_frz_clr;
    wr && paddr == eco_pkg::OFF_OVF_CLR && &pwdata[30:0] && event_in == '0 |=> frozen == '0;
  endproperty
  a_frz_clr: assert property (p_frz_clr) else $error("still frozen after clear");
  property p_cyc_inc; cycle_tick |=> cycle_count == $past(cycle_count) + 64'h1; endproperty
  a_cyc_inc: assert property (p_cyc_inc) else $error("cycle counter missed a tick");
  property p_cyc_hold; !cycle_tick |=> $stable(cycle_count); endproperty
  a_cyc_hold: assert property (p_cyc_hold) else $error("cycle counter moved");
  property p_resv_zero;
    pready && !pwrite && paddr == eco_pkg::OFF_CTRL_LO |-> !prdata[10] && !prdata[8];
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit set");
endmodule // eco_overflow_ctrl_monitor
`default_nettype wire

// ===== eco_overflow_ctrl_bench.sv
// Bench: random and corner cases for the overflow control block
`timescale 1ns/1ns
`default_nettype none
module eco_overflow_ctrl_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [30:0] event_in, frozen;
  logic [63:0] cycle_count;
  int          n_fail = 0, checks = 0, cyc = 0, n_tick = 0, lim, tn = 0;
  eco_overflow_ctrl i_eco_overflow_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
    .cycle_tick(cycle_tick), .cycle_count(cycle_count), .frozen(frozen));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // About 1000 cycles are needed; the margin covers a slow answer
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checks++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench timeout ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", e, pslverr);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cnt(input int i, input logic w, inout logic [63:0] v);
    apb(1'b1, eco_pkg::OFF_CNT_SEL, 32'(i));
    apb(w, eco_pkg::OFF_CNT_LO, v[31:0]);
    if (!w) v[31:0] = r;
    apb(w, eco_pkg::OFF_CNT_HI, v[63:32]);
    if (!w) v[63:32] = r;
  endtask
  task automatic run(input logic [31:0] h, c, input int idx, input logic [63:0] s);
    int          acnt, ix[2];
    logic [30:0] inr, ovf, frz;
    logic [63:0] v[2], g;
    acnt = (h[8] && h[9]) ? h[4:0] : eco_pkg::N_RESET;
    inr  = (acnt == 0) ? '1 : (31'h1 << acnt) - 31'h1;
    ix   = '{idx, (acnt > 0 && acnt < 31) ? acnt : 0};
    v   = '{s, 64'h0};
    apb(1'b1, eco_pkg::OFF_HYP_CFG, h);
    apb(1'b0, eco_pkg::OFF_HYP_CFG, 32'h0);
    chk("hyp cfg", h & 32'h0000_0F1F, r);
    apb(1'b1, eco_pkg::OFF_CTRL_LO, c);
    apb(1'b0, eco_pkg::OFF_CTRL_LO, 32'h0);
    chk("count", (h[10] && h[11]) ? h[4:0] : eco_pkg::N_RESET, r[15:11]);
    cnt(ix[0], 1'b1, v[0]);
    cnt(ix[1], 1'b1, v[1]);
    // Second pass shows a frozen counter resuming with no increment lost
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, eco_pkg::OFF_OVF_CLR, 32'h7FFF_FFFF);
      ovf = '0;
      for (int t = 0; t < 8; t++) begin
        event_in   <= 31'($urandom) | (31'h1 << ix[0]) | (31'h1 << ix[1]);
        cycle_tick <= 1'($urandom);
        @(posedge pclk);
        n_tick += cycle_tick;
        frz = (c[9] && |(ovf & inr)) ? inr : '0;
        chk("frozen", frz, frozen);
        for (int j = 0; j < 2; j++) begin
          if (!frz[ix[j]]) begin
            if ((c[7] && inr[ix[j]]) ? &v[j] : &v[j][31:0]) ovf[ix[j]] = 1'b1;
            v[j] = v[j] + 64'h1;
          end
        end
      end
      event_in   <= '0;
      cycle_tick <= 1'b0;
      apb(1'b0, eco_pkg::OFF_OVF_STAT, 32'h0);
      chk("overflow", {1'b0, ovf}, r);
      cnt(ix[0], 1'b0, g);
      chk("counter", v[0], g);
      cnt(ix[1], 1'b0, g);
      chk("other", v[1], g);
      chk("cycles", n_tick, cycle_count);
    end
    tn++;
    $display("Test %0d done", tn);
  endtask
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    pstrb      = 4'hF;
    event_in   = '0;
    cycle_tick = 1'b0;
    void'($urandom(32'h9624));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, eco_pkg::OFF_CTRL_LO, 32'h0);
    chk("ctrl reset", 32'h0000_A000, r & 32'h0000_FF80);
    apb(1'b0, eco_pkg::OFF_CTRL_HI, 32'h0);
    chk("ctrl high", 32'h0, r);
    apb(1'b1, 8'h24, 32'h0, 1'b1);
    apb(1'b1, eco_pkg::OFF_OVF_STAT, 32'h0, 1'b1);
    apb(1'b1, eco_pkg::OFF_CTRL_LO, 32'hFFFF_FFFF);
    apb(1'b0, eco_pkg::OFF_CTRL_LO, 32'h0);
    chk("ctrl bits", 32'h0000_A280, r & 32'h0000_FF80);
    pstrb <= 4'h0;
    apb(1'b1, eco_pkg::OFF_CTRL_LO, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, eco_pkg::OFF_CTRL_LO, 32'h0);
    chk("ctrl strobe", 32'h0000_A280, r & 32'h0000_FF80);
    tn++;
    $display("Test %0d done", tn);
    lim = 1 + $urandom % 29;
    run(32'h0, 32'h200, 3, 64'hFFFF_FFFE);
    run(32'h0, 32'h000, 3, 64'hFFFF_FFFE);
    run(32'h0, 32'h280, 3, 64'hFFFF_FFFE);
    run(32'h0, 32'h280, 3, 64'hFFFF_FFFF_FFFF_FFFE);
    run(32'h300 | lim, 32'h280, lim - 1, 64'hFFFF_FFFF_FFFF_FFFE);
    run(32'hD05, 32'h200, 10, 64'hFFFF_FFFE);
    run(32'h300, 32'h280, 30, 64'hFFFF_FFFF_FFFF_FFFE);
    run(32'h308, 32'h280, 12, 64'hFFFF_FFFE);
    // Reset in mid-run: control state and the cycle counter start over
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    n_tick = 0;
    apb(1'b0, eco_pkg::OFF_CTRL_LO, 32'h0);
    chk("ctrl reset", 32'h0000_A000, r & 32'h0000_FF80);
    chk("frozen reset", 31'h0, frozen);
    chk("cycles", n_tick, cycle_count);
    tn++;
    $display("Test %0d done", tn);
    conclude();
  end
endmodule // eco_overflow_ctrl_bench
bind eco_overflow_ctrl eco_overflow_ctrl_monitor i_eco_overflow_ctrl_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_in(event_in), .cycle_tick(cycle_tick), .cycle_count(cycle_count), .frozen(frozen));
`default_nettype wire
